// ### ispo_pkg.sv
package ispo_pkg;
  // ==========================================================
  // Array geometry
  localparam int ARRAY_COLS  = 668;
  localparam int ARRAY_ROWS  = 496;
  localparam int DARK_COLS   = 18;
  localparam int DARK_ROWS   = 6;
  localparam int ACTIVE_COLS = 649;
  localparam int ACTIVE_ROWS = 489;
  localparam int BORDER      = 4;
  localparam int IMG_COL0    = DARK_COLS + BORDER;
  localparam int IMG_ROW0    = DARK_ROWS + BORDER;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MCLK_MAX_MHZ   = 27;
  localparam int PIX_CYC        = 2;
  localparam int HBLANK_BASE    = 113;
  localparam int HBLANK_MIN     = 9;
  localparam int VBLANK_MIN     = 5;
  localparam int BLACK_SHIFT    = 4;
  localparam int SKEW_MAX_HALF  = 2;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] REG_WIDTH  = 8'h00;
  localparam logic [7:0] REG_HEIGHT = 8'h01;
  localparam logic [7:0] REG_HBLANK = 8'h02;
  localparam logic [7:0] REG_VBLANK = 8'h03;
  localparam logic [7:0] REG_SKEW   = 8'h04;
  localparam logic [7:0] REG_LMODE  = 8'h05;
  localparam logic [7:0] REG_STATUS = 8'h06;
  localparam logic [7:0] REG_BLACK  = 8'h07;
  // ==========================================================
  // Values after reset
  localparam logic [9:0] RST_WIDTH  = 10'h27F;
  localparam logic [9:0] RST_HEIGHT = 10'h1DF;
  localparam logic [9:0] RST_HBLANK = 10'h083;
  localparam logic [9:0] RST_VBLANK = 10'h01C;
  localparam logic [2:0] RST_SKEW   = 3'h0;
  localparam logic       RST_LMODE  = 1'b0;
  // ==========================================================
  // Carriers
  typedef enum logic [1:0] {
    ISPO_GREEN_R,
    ISPO_RED,
    ISPO_BLUE,
    ISPO_GREEN_B
  } ispo_color_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } ispo_bus_t;

  typedef struct packed {
    logic        frame;
    logic        line;
    logic [9:0]  data;
    ispo_color_t color;
  } ispo_pix_t;
endpackage

// ### ispo_pixel_out.sv
`timescale 1ns/1ps
module ispo_pixel_out #(
  parameter int COL_W = 11,
  parameter int ROW_W = 10
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Register port
  input  wire ispo_pkg::ispo_bus_t bus_in,
  output logic [15:0]           rdata_out,
  // Pins and sensor data
  input  wire logic             oe_n_in,
  input  wire logic             standby_in,
  input  wire logic [9:0]       adc_pixel_in,
  // Pixel port
  output logic                  pixel_strobe_out,
  output ispo_pkg::ispo_pix_t   pix_out,
  output logic                  pixel_oe_out
);
  import ispo_pkg::*;

  if (COL_W < 11 || ROW_W < 10) begin : g_chk
    $error("ispo_pixel_out: counters too narrow");
  end

  // ==========================================================
  // Registers
  logic [9:0] width;
  logic [9:0] height;
  logic [9:0] hblank;
  logic [9:0] vblank;
  logic [2:0] skew;
  logic       lmode;
  logic [9:0] black;

  wire logic [9:0] wd10  = bus_in.wdata[9:0];
  wire logic       wr_w  = bus_in.wr && bus_in.addr == REG_WIDTH;
  wire logic       wr_h  = bus_in.wr && bus_in.addr == REG_HEIGHT;
  wire logic       wr_hb = bus_in.wr && bus_in.addr == REG_HBLANK;
  wire logic       wr_vb = bus_in.wr && bus_in.addr == REG_VBLANK;
  wire logic       wr_sk = bus_in.wr && bus_in.addr == REG_SKEW;
  wire logic       wr_lm = bus_in.wr && bus_in.addr == REG_LMODE;
  // Clamp at write so the timing counters never see illegal blanking
  wire logic [9:0] hb_w  = (wd10 < 10'(HBLANK_MIN)) ? 10'(HBLANK_MIN) : wd10;
  wire logic [9:0] vb_w  = (wd10 < 10'(VBLANK_MIN)) ? 10'(VBLANK_MIN) : wd10;
  wire logic signed [2:0] sk_in = bus_in.wdata[2:0];
  wire logic [2:0] sk_w  = (sk_in > 3'sd2) ? 3'sd2 :
                           (sk_in < -3'sd2) ? -3'sd2 : sk_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      width  <= RST_WIDTH;
      height <= RST_HEIGHT;
      hblank <= RST_HBLANK;
      vblank <= RST_VBLANK;
      skew   <= RST_SKEW;
      lmode  <= RST_LMODE;
    end else begin
      if (wr_w) width <= wd10;
      if (wr_h) height <= wd10;
      if (wr_hb) hblank <= hb_w;
      if (wr_vb) vblank <= vb_w;
      if (wr_sk) skew <= sk_w;
      if (wr_lm) lmode <= bus_in.wdata[0];
    end
  end

  // ==========================================================
  // Pin synchronisers
  logic [2:0] oe_sync;
  logic [2:0] sb_sync;
  logic       oe_n;
  logic       standby;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      oe_sync <= 3'h7;
      sb_sync <= 3'h0;
      oe_n    <= 1'b1;
      standby <= 1'b0;
    end else begin
      oe_sync <= {oe_sync[1:0], oe_n_in};
      sb_sync <= {sb_sync[1:0], standby_in};
      if (oe_sync[1] == oe_sync[2]) oe_n <= oe_sync[2];
      if (sb_sync[1] == sb_sync[2]) standby <= sb_sync[2];
    end
  end

  // ==========================================================
  // Pixel phase and strobe
  logic pix_phase;
  wire logic pix_en = !pix_phase;
  wire logic signed [2:0] skew_s = skew;
  // Only whole-clock shifts exist on a single clock edge
  wire logic invert = (skew_s >= 3'sd2) || (skew_s <= -3'sd2);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pix_phase        <= 1'b0;
      pixel_strobe_out <= 1'b0;
    end else begin
      pix_phase        <= !pix_phase;
      pixel_strobe_out <= pix_phase ^ invert;
    end
  end

  // ==========================================================
  // Raster counters
  logic [COL_W-1:0] col;
  logic [ROW_W-1:0] row;

  wire logic [COL_W-1:0] col_last = COL_W'(width) + COL_W'(HBLANK_BASE) + COL_W'(hblank);
  wire logic [ROW_W-1:0] row_last = ROW_W'(height) + ROW_W'(vblank) + ROW_W'(1);
  wire logic col_wrap = col >= col_last;
  wire logic row_wrap = row >= row_last;
  wire logic in_cols  = col <= COL_W'(width);
  wire logic frame_a  = row <= ROW_W'(height);
  wire logic line_a   = frame_a && in_cols;
  // Dark rows sit at the end of vertical blanking
  wire logic dark_row = row > row_last - ROW_W'(DARK_ROWS);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      col <= '0;
      row <= '0;
    end else if (standby) begin
      col <= '0;
      row <= '0;
    end else if (pix_en) begin
      col <= col_wrap ? '0 : col + COL_W'(1);
      if (col_wrap) row <= row_wrap ? '0 : row + ROW_W'(1);
    end
  end

  // ==========================================================
  // Black level and correction
  wire logic signed [11:0] diff = $signed({2'b00, adc_pixel_in}) - $signed({2'b00, black});
  wire logic signed [11:0] step = diff >>> BLACK_SHIFT;
  wire logic [11:0] blk_sum = {2'b00, black} + step;
  wire logic [9:0] next_black = blk_sum[9:0];
  wire logic [9:0] corr = (adc_pixel_in > black) ? adc_pixel_in - black : 10'h000;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      black <= 10'h000;
    end else if (pix_en && !standby && dark_row && in_cols) begin
      black <= next_black;
    end
  end

  // ==========================================================
  // Colour and output
  wire logic r_odd = row[0] ^ IMG_ROW0[0];
  wire logic c_odd = col[0] ^ IMG_COL0[0];
  ispo_color_t color_a;
  assign color_a = !r_odd ? (c_odd ? ISPO_RED : ISPO_GREEN_R)
                          : (c_odd ? ISPO_GREEN_B : ISPO_BLUE);
  wire logic line_q = lmode ? in_cols : line_a;

  ispo_pix_t next_pix;
  assign next_pix.frame = frame_a && !standby;
  assign next_pix.line  = line_q && !standby;
  assign next_pix.data  = (line_a && !standby) ? corr : 10'h000;
  assign next_pix.color = color_a;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pix_out <= '0;
    end else if (pix_en) begin
      pix_out <= next_pix;
    end
  end

  assign pixel_oe_out = !oe_n;

  // ==========================================================
  // Read port
  wire logic [15:0] stat = {standby, pix_out.frame, pix_out.line, 3'h0, row[9:0]};
  logic [15:0] rmux;
  always_comb begin
    case (bus_in.addr)
      REG_WIDTH:  rmux = {6'h00, width};
      REG_HEIGHT: rmux = {6'h00, height};
      REG_HBLANK: rmux = {6'h00, hblank};
      REG_VBLANK: rmux = {6'h00, vblank};
      REG_SKEW:   rmux = {13'h0000, skew};
      REG_LMODE:  rmux = {15'h0000, lmode};
      REG_STATUS: rmux = stat;
      REG_BLACK:  rmux = {6'h00, black};
      default:    rmux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) rdata_out <= 16'h0000;
    else rdata_out <= bus_in.rd ? rmux : 16'h0000;
  end

  // ==========================================================
  // Checks
  chk_strobe_toggle: assert property (@(posedge clk_in) disable iff (rst_in)
    !$past(rst_in) && !$past(rst_in, 2) && !$past(wr_sk, 2) && $stable(invert)
    |-> pixel_strobe_out != $past(pixel_strobe_out))
    else $error("strobe did not toggle");

  chk_strobe_blank: assert property (@(posedge clk_in) disable iff (rst_in)
    !pix_out.frame && !wr_sk && $stable(invert) |-> ##2 $changed(pixel_strobe_out))
    else $error("strobe stopped in blanking");

  chk_strobe_edge: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(pixel_strobe_out) && !invert && !$past(invert) |-> $stable(pix_out) && $past(pix_en, 2))
    else $error("strobe rise not one clock after data");

  chk_skew_invert: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(invert) && $stable(invert) |-> pixel_strobe_out == !$past(pix_phase))
    else $error("shifted strobe wrong phase");

  chk_line_frame: assert property (@(posedge clk_in) disable iff (rst_in)
    !lmode && !$past(lmode) && !$past(lmode, 2) && pix_out.line |-> pix_out.frame)
    else $error("line outside frame");

  chk_blank_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    !pix_out.line |-> pix_out.data == 10'h000)
    else $error("data not zero in blanking");

  chk_pixel_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    pix_en |=> ##1 $stable(pix_out))
    else $error("pixel changed mid period");

  chk_oe_off: assert property (@(posedge clk_in) disable iff (rst_in)
    oe_sync[1] && oe_sync[2] |=> !pixel_oe_out)
    else $error("drivers on while disabled");

  chk_standby_off: assert property (@(posedge clk_in) disable iff (rst_in)
    standby && $past(standby) && $past(standby, 2) |-> !pix_out.frame && row == '0)
    else $error("imaging active in standby");

  chk_hblank_min: assert property (@(posedge clk_in) disable iff (rst_in)
    hblank >= 10'(HBLANK_MIN))
    else $error("hblank below minimum");

  chk_reset_dflt: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(rst_in) |-> width == RST_WIDTH && hblank == RST_HBLANK && skew == RST_SKEW)
    else $error("register not at default");

  chk_bayer_red: assert property (@(posedge clk_in) disable iff (rst_in)
    pix_en && !standby ##1 pix_out.color == ISPO_RED |-> !$past(r_odd) && $past(c_odd))
    else $error("bayer order wrong");

  chk_black_dark: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(black) |-> $past(dark_row) && $past(in_cols) && $past(pix_en) && !$past(standby))
    else $error("black level moved outside dark rows");

  chk_frame_low: assert property (@(posedge clk_in) disable iff (rst_in)
    pix_en && !frame_a |=> !pix_out.frame)
    else $error("frame high outside frame rows");

  chk_frame_high: assert property (@(posedge clk_in) disable iff (rst_in)
    pix_en && frame_a && !standby |=> pix_out.frame)
    else $error("frame low inside frame rows");

  chk_pixel_data: assert property (@(posedge clk_in) disable iff (rst_in)
    pix_en && line_a && !standby |=> pix_out.data == $past(corr))
    else $error("pixel value not launched");

  chk_row_step: assert property (@(posedge clk_in) disable iff (rst_in)
    pix_en && col_wrap && !row_wrap && !standby |=> row == $past(row) + ROW_W'(1))
    else $error("row did not advance at line end");

  chk_line_mode: assert property (@(posedge clk_in) disable iff (rst_in)
    pix_en && lmode && in_cols && !standby |=> pix_out.line)
    else $error("line low in column mode");

  chk_line_blank: assert property (@(posedge clk_in) disable iff (rst_in)
    pix_en && !lmode && !line_a |=> !pix_out.line)
    else $error("line high outside valid area");

  chk_standby_sync: assert property (@(posedge clk_in) disable iff (rst_in)
    sb_sync[1] && sb_sync[2] |=> standby)
    else $error("standby not taken after sync");
endmodule

// ### ispo_cap_model.sv
`timescale 1ns/1ps
// ==========================================================
// Capture logic on the far side of the pixel port
module ispo_cap_model
  import ispo_pkg::*;
(
  // Pixel link
  input  wire logic      clk_in,
  input  wire logic      rst_in,
  input  wire logic      strobe_in,
  input  wire ispo_pix_t pix_in,
  // Observations
  output int             err,
  output int             period,
  output int             act,
  output int             rows,
  output logic [9:0]     px,
  output logic [7:0]     colors,
  output logic           vline
);
  logic      ps;
  logic      pl;
  logic      pf;
  ispo_pix_t pp;
  int        n;
  int        cnt;
  int        ac;
  int        rc;
  // Master clock comes from the bench; its rate limit binds the source
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ps = 1'b0; pl = 1'b0; pf = 1'b0; pp = '0; n = 0; cnt = 0; ac = 0; rc = 0;
      err = 0; period = 0; act = 0; rows = 0; px = '0; colors = '0; vline = 1'b0;
    end else begin
      n++;
      // Strobe lags reset release by one cycle, so the first edges are skipped
      if (n > 2 && strobe_in === ps) err++;
      if (!ps && strobe_in) begin
        if (pp !== pix_in) err++;
        if (!pix_in.line && pix_in.data !== 10'h000) err++;
        cnt++;
        if (pix_in.line && !pl) begin
          if (rc > 0) period = cnt;
          cnt = 0;
          ac = 0;
          if (pix_in.frame) rc++;
          else vline = 1'b1;
        end
        if (pix_in.line) begin
          if (pix_in.frame && ac < 2 && rc < 3) colors[((rc - 1) * 2 + ac) * 2 +: 2] = pix_in.color;
          ac++;
          px = pix_in.data;
        end
        if (!pix_in.line && pl) act = ac;
        if (!pix_in.frame && pf) begin
          rows = rc;
          rc = 0;
        end
        pl = pix_in.line;
        pf = pix_in.frame;
      end
      ps = strobe_in;
      pp = pix_in;
    end
  end
endmodule

// ### test_image_sensor_pixel_output.sv
`timescale 1ns/1ps
module test_image_sensor_pixel_output;
  import ispo_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [15:0] d; logic [15:0] e;} ispo_row_t;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        oe_n_in = 1'b0;
  logic        standby_in = 1'b0;
  logic [9:0]  adc_pixel_in = 10'h000;
  ispo_bus_t   bus_in = '0;
  logic [15:0] rdata_out;
  logic        pixel_strobe_out;
  logic        pixel_oe_out;
  ispo_pix_t   pix_out;
  int          err, period, act, rows;
  int          bad_count = 0;
  int          checks = 0;
  logic [9:0]  px;
  logic [9:0]  blk;
  logic [7:0]  colors;
  logic        vline;
  logic [15:0] r;
  ispo_row_t   tbl [16] = '{'{0, 8'h00, 0, 16'h027F}, '{0, 8'h01, 0, 16'h01DF}, '{0, 8'h02, 0, 16'h0083},
    '{0, 8'h03, 0, 16'h001C}, '{0, 8'h04, 0, 16'h0000}, '{0, 8'h05, 0, 16'h0000}, '{0, 8'h08, 0, 16'h0000},
    '{1, 8'h00, 16'h0007, 16'h0007}, '{1, 8'h01, 16'h0003, 16'h0003}, '{1, 8'h02, 16'h0002, 16'h0009},
    '{1, 8'h03, 16'h0001, 16'h0005}, '{1, 8'h02, 16'h0009, 16'h0009}, '{1, 8'h03, 16'h0005, 16'h0005},
    '{1, 8'h04, 16'h0001, 16'h0001}, '{1, 8'h08, 16'h1234, 16'h0000}, '{1, 8'h07, 16'h03FF, 16'h0000}};

  always #5 clk_in = ~clk_in;

  ispo_pixel_out uut (.clk_in, .rst_in, .bus_in, .rdata_out, .oe_n_in, .standby_in, .adc_pixel_in,
    .pixel_strobe_out, .pix_out, .pixel_oe_out);
  ispo_cap_model cap (.clk_in, .rst_in, .strobe_in(pixel_strobe_out), .pix_in(pix_out), .err, .period,
    .act, .rows, .px, .colors, .vline);

  // ==========================================================
  // Bus and check helpers
  task print_verdict;
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    bus_in <= '0;
  endtask
  task rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge clk_in);
    bus_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_in);
    bus_in <= '0;
    #1 q = rdata_out;
  endtask
  // Strobe level just after the edge that launches a new pixel
  task strobe_at_change(input logic e);
    ispo_color_t c0;
    #1;
    for (int i = 0; i < 8; i++) begin
      c0 = pix_out.color;
      @(posedge clk_in);
      #1;
      if (pix_out.color != c0) chk({15'h0000, pixel_strobe_out}, {15'h0000, e});
    end
  endtask
  // Frame may run long after mid-frame resizing, hence the wide bound
  task wait_fr(input logic lvl);
    int i;
    for (i = 0; i < 30000; i++) begin
      @(posedge clk_in);
      if (pix_out.frame === lvl) break;
    end
    if (i == 30000) begin
      bad_count++;
      print_verdict();
    end
  endtask

  // ==========================================================
  // Sequence
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (tbl[k]) begin
      if (tbl[k].wr) wr(tbl[k].a, tbl[k].d);
      rd(tbl[k].a, r);
      chk(r, tbl[k].e);
    end
    wr(8'h04, 16'h0000);
    adc_pixel_in <= 10'h300;
    wait_fr(1'b0); wait_fr(1'b1); wait_fr(1'b0); wait_fr(1'b1); wait_fr(1'b0);
    chk(16'(rows), 16'h0004);
    chk(16'(act), 16'h0008);
    chk(16'(period), 16'(HBLANK_BASE + 9 + 8));
    chk({8'h00, colors}, 16'h00E4);
    chk({15'h0000, vline}, 16'h0000);
    wait_fr(1'b1);
    repeat (8) @(posedge clk_in);
    rd(8'h07, r);
    blk = r[9:0];
    repeat (4) @(posedge clk_in);
    chk({15'h0000, blk != 10'h000 && blk <= 10'h300}, 16'h0001);
    chk({6'h00, px}, {6'h00, 10'h300 - blk});
    wr(8'h05, 16'h0001);
    wait_fr(1'b0); wait_fr(1'b1);
    chk({15'h0000, vline}, 16'h0001);
    wr(8'h05, 16'h0000);
    standby_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk({4'h0, pix_out.frame, pix_out.line, pix_out.data}, 16'h0000);
    rd(8'h06, r);
    chk({15'h0000, r[15]}, 16'h0001);
    @(posedge clk_in);
    standby_in <= 1'b0;
    oe_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk({15'h0000, pixel_oe_out}, 16'h0000);
    oe_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk({15'h0000, pixel_oe_out}, 16'h0001);
    chk(16'(err), 16'h0000);
    strobe_at_change(1'b0);
    wr(8'h04, 16'h0003);
    rd(8'h04, r);
    chk(r, 16'h0002);
    strobe_at_change(1'b1);
    wr(8'h04, 16'h0005);
    rd(8'h04, r);
    chk(r, 16'h0006);
    strobe_at_change(1'b1);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(8'h00, r);
    chk(r, 16'h027F);
    rd(8'h04, r);
    chk(r, 16'h0000);
    print_verdict();
  end
endmodule
